// ==== hdl/par_out_pkg.sv ====
// constants, register map and carrier types of the parallel result output port
package par_out_pkg;
  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 100000; // 0.1 ms timer step
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CYCLE = 8'h04;
  localparam logic [7:0] OFS_DELAY = 8'h08;
  localparam logic [7:0] OFS_WIDTH = 8'h0c;
  localparam logic [7:0] OFS_TIMEOUT = 8'h10;
  localparam logic [7:0] OFS_PULSE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1c;
  localparam logic [7:0] OFS_STATE = 8'h20;
  // ----------------------------------------------------------------
  // reset values and limits (timers in 0.1 ms ticks, pulse in 1 ms, timeout in 0.1 s)
  // ----------------------------------------------------------------
  localparam logic [19:0] CYCLE_RST = 20'h00064;
  localparam logic [19:0] CYCLE_MIN = 20'h00014;
  localparam logic [19:0] CYCLE_MAX = 20'h186a0;
  localparam logic [19:0] DELAY_RST = 20'h00000;
  localparam logic [19:0] DELAY_MAX = 20'h02710;
  localparam logic [19:0] WIDTH_RST = 20'h00032;
  localparam logic [19:0] WIDTH_MIN = 20'h0000a;
  localparam logic [19:0] WIDTH_MAX = 20'h02710;
  localparam logic [19:0] TO_RST = 20'h00064;
  localparam logic [19:0] TO_MIN = 20'h0000a;
  localparam logic [19:0] TO_MAX = 20'h00258;
  localparam logic [19:0] TICKS_PER_TENTH_S = 20'h003e8;
  localparam logic [19:0] TICKS_PER_MS = 20'h0000a;
  localparam logic [7:0] PULSE_RST = 8'h00;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int STAT_W = 3;
  localparam int ST_TIMEOUT = 0;
  localparam int ST_SENT = 1;
  localparam int ST_OVERRUN = 2;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int DATA_W = 16;
  typedef struct packed {
    logic readySel;  // 1: ready at image capture done, 0: at measurement done
    logic oneShot;   // 1: judgment line one-shot, 0: level
    logic handshake; // 1: wait for acknowledge per result
    logic polOk;     // 1: lines active on OK, 0: active on NG
  } ctrl_t;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic ng;
  } result_t;
endpackage

// ==== hdl/par_result_out.sv ====
// parallel result output port with strobe timing, handshake, judgment and ready lines
`timescale 1ns/1ps
module par_result_out #(
  parameter int TickCycles = par_out_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement side
  input wire logic resultValid,
  input wire par_out_pkg::result_t resultIn,
  input wire logic trigIn,
  input wire logic captureDone,
  input wire logic measDone,
  // receiving controller side
  input wire logic ackIn,
  output logic [15:0] result_data_lines,
  output logic resultStrobe,
  output logic judgeOut,
  output logic readyOut,
  output logic irq
);
  typedef enum {ST_IDLE, ST_DELAY, ST_STROBE, ST_WAIT} state_t;

  // keeps a written timer value inside its legal range
  function automatic logic [19:0] clampVal(input logic [19:0] v, input logic [19:0] lo, input logic [19:0] hi);
    clampVal = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  par_out_pkg::ctrl_t ctrl_reg;
  logic [19:0] cycle_reg, delay_reg, width_reg, timeout_reg;
  logic [7:0] pulse_reg;
  logic [par_out_pkg::STAT_W-1:0] status_reg, mask_reg, status_next;
  state_t state_reg;
  logic [31:0] tickDiv_reg;
  logic tick;
  logic [19:0] tmr_reg, cyc_reg, pulseCnt_reg;
  logic cycRun_reg;
  par_out_pkg::result_t pend_reg;
  logic pendValid_reg;
  logic [31:0] rdNext;
  logic wrEn, setupRd, mapped, loadEvt, toHit, sentEvt;
  logic [19:0] timeoutTicks, pulseTicks;

  assign wrEn = psel && penable && pwrite;
  assign setupRd = psel && !penable && !pwrite;
  assign timeoutTicks = 20'(timeout_reg * par_out_pkg::TICKS_PER_TENTH_S);
  assign pulseTicks = 20'({12'h000, pulse_reg} * par_out_pkg::TICKS_PER_MS);

  // ----------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped offsets
  // ----------------------------------------------------------------
  always_comb
  begin
    mapped = 1'b1;
    rdNext = 32'h0000_0000;
    case (paddr)
      par_out_pkg::OFS_CTRL: rdNext = {28'h0000000, ctrl_reg};
      par_out_pkg::OFS_CYCLE: rdNext = {12'h000, cycle_reg};
      par_out_pkg::OFS_DELAY: rdNext = {12'h000, delay_reg};
      par_out_pkg::OFS_WIDTH: rdNext = {12'h000, width_reg};
      par_out_pkg::OFS_TIMEOUT: rdNext = {12'h000, timeout_reg};
      par_out_pkg::OFS_PULSE: rdNext = {24'h000000, pulse_reg};
      par_out_pkg::OFS_STATUS: rdNext = {29'h00000000, status_reg};
      par_out_pkg::OFS_MASK: rdNext = {29'h00000000, mask_reg};
      par_out_pkg::OFS_STATE: rdNext = {26'h0000000, pendValid_reg, readyOut, judgeOut, resultStrobe,
                                        state_reg != ST_IDLE, state_reg == ST_WAIT};
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read data is captured in the setup cycle so it comes from a flip-flop
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (setupRd)
      prdata <= rdNext;
  end

  // configuration writes, clamped so the timers never see an illegal value
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ctrl_reg <= par_out_pkg::CTRL_RST;
      cycle_reg <= par_out_pkg::CYCLE_RST;
      delay_reg <= par_out_pkg::DELAY_RST;
      width_reg <= par_out_pkg::WIDTH_RST;
      timeout_reg <= par_out_pkg::TO_RST;
      pulse_reg <= par_out_pkg::PULSE_RST;
      mask_reg <= '0;
    end
    else if (wrEn)
    begin
      case (paddr)
        par_out_pkg::OFS_CTRL: ctrl_reg <= pwdata[par_out_pkg::CTRL_W-1:0];
        par_out_pkg::OFS_CYCLE: cycle_reg <= clampVal(pwdata[19:0], par_out_pkg::CYCLE_MIN, par_out_pkg::CYCLE_MAX);
        par_out_pkg::OFS_DELAY: delay_reg <= clampVal(pwdata[19:0], par_out_pkg::DELAY_RST, par_out_pkg::DELAY_MAX);
        par_out_pkg::OFS_WIDTH: width_reg <= clampVal(pwdata[19:0], par_out_pkg::WIDTH_MIN, par_out_pkg::WIDTH_MAX);
        par_out_pkg::OFS_TIMEOUT: timeout_reg <= clampVal(pwdata[19:0], par_out_pkg::TO_MIN, par_out_pkg::TO_MAX);
        par_out_pkg::OFS_PULSE: pulse_reg <= pwdata[7:0];
        par_out_pkg::OFS_MASK: mask_reg <= pwdata[par_out_pkg::STAT_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sticky status and interrupt; a new event wins over a write-one clear
  // ----------------------------------------------------------------
  always_comb
  begin
    status_next = status_reg;
    if (wrEn && paddr == par_out_pkg::OFS_STATUS)
      status_next = status_reg & ~pwdata[par_out_pkg::STAT_W-1:0];
    if (toHit)
      status_next[par_out_pkg::ST_TIMEOUT] = 1'b1;
    if (sentEvt)
      status_next[par_out_pkg::ST_SENT] = 1'b1;
    if (resultValid && pendValid_reg && !loadEvt)
      status_next[par_out_pkg::ST_OVERRUN] = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // 0.1 ms tick divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || tickDiv_reg >= 32'(TickCycles - 1))
      tickDiv_reg <= 32'h0000_0000;
    else
      tickDiv_reg <= tickDiv_reg + 32'h0000_0001;
  end

  assign tick = (tickDiv_reg >= 32'(TickCycles - 1));

  // ----------------------------------------------------------------
  // pending result: one slot, the newest result replaces an unsent one
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      pend_reg <= '0;
      pendValid_reg <= 1'b0;
    end
    else if (resultValid)
    begin
      pend_reg <= resultIn;
      pendValid_reg <= 1'b1;
    end
    else if (loadEvt)
      pendValid_reg <= 1'b0;
  end

  // a new result goes out only once the output cycle has elapsed since the last one
  assign loadEvt = (state_reg == ST_IDLE) && pendValid_reg && (!cycRun_reg || cyc_reg >= cycle_reg);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cyc_reg <= '0;
      cycRun_reg <= 1'b0;
    end
    else if (loadEvt)
    begin
      cyc_reg <= '0;
      cycRun_reg <= 1'b1;
    end
    else if (tick && cyc_reg < par_out_pkg::CYCLE_MAX)
      cyc_reg <= cyc_reg + 20'h00001;
  end

  // ----------------------------------------------------------------
  // output sequencer
  // ----------------------------------------------------------------
  assign toHit = (state_reg == ST_WAIT) && !ackIn && tmr_reg >= timeoutTicks;
  assign sentEvt = ((state_reg == ST_STROBE) && !ctrl_reg.handshake && tmr_reg >= width_reg)
                   || ((state_reg == ST_WAIT) && ackIn);

  // the phase timer restarts on entering delay and strobe, not on entering wait; timeout counts from strobe rise
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      tmr_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (loadEvt)
          begin
            state_reg <= ST_DELAY;
            tmr_reg <= '0;
          end
        ST_DELAY:
          if (tmr_reg >= delay_reg)
          begin
            state_reg <= ST_STROBE;
            tmr_reg <= '0;
          end
          else if (tick)
            tmr_reg <= tmr_reg + 20'h00001;
        ST_STROBE:
          if (tmr_reg >= width_reg)
            state_reg <= ctrl_reg.handshake ? ST_WAIT : ST_IDLE;
          else if (tick)
            tmr_reg <= tmr_reg + 20'h00001;
        ST_WAIT:
          if (ackIn || toHit)
            state_reg <= ST_IDLE;
          else if (tick)
            tmr_reg <= tmr_reg + 20'h00001;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // data lines show the judgment bits in the chosen polarity, held until the next load
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      result_data_lines <= '0;
    else if (loadEvt)
      result_data_lines <= ctrl_reg.polOk ? ~pend_reg.data : pend_reg.data;
  end

  // strobe is high in the strobe phase and through the acknowledge wait
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      resultStrobe <= 1'b0;
    else
      resultStrobe <= (state_reg == ST_DELAY && tmr_reg >= delay_reg)
                      || (state_reg == ST_STROBE && (tmr_reg < width_reg || ctrl_reg.handshake))
                      || (state_reg == ST_WAIT && !ackIn && !toHit);
  end

  // ----------------------------------------------------------------
  // judgment line; a zero pulse time gives no pulse at all
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      judgeOut <= 1'b0;
      pulseCnt_reg <= '0;
    end
    else if (loadEvt)
    begin
      if (!ctrl_reg.oneShot)
        judgeOut <= pend_reg.ng ^ ctrl_reg.polOk;
      else
      begin
        judgeOut <= (pend_reg.ng ^ ctrl_reg.polOk) && pulseTicks != 20'h00000;
        pulseCnt_reg <= pulseTicks;
      end
    end
    else if (ctrl_reg.oneShot && tick && pulseCnt_reg != 20'h00000)
    begin
      pulseCnt_reg <= pulseCnt_reg - 20'h00001;
      if (pulseCnt_reg == 20'h00001)
        judgeOut <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // ready line: trigger clears it, the selected processing point sets it
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      readyOut <= 1'b0;
    else if (ctrl_reg.readySel ? captureDone : measDone)
      readyOut <= 1'b1;
    else if (trigIn)
      readyOut <= 1'b0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_judgePol;
    loadEvt && !ctrl_reg.oneShot |=> judgeOut == ($past(pend_reg.ng) ^ $past(ctrl_reg.polOk));
  endproperty
  a_judgePol: assert property (p_judgePol) else $error("judgment polarity wrong");

  property p_cycle;
    loadEvt && cycRun_reg |-> cyc_reg >= cycle_reg;
  endproperty
  a_cycle: assert property (p_cycle) else $error("result sent before output cycle");

  property p_delay;
    state_reg == ST_DELAY && tmr_reg < delay_reg |=> !resultStrobe;
  endproperty
  a_delay: assert property (p_delay) else $error("strobe before delay");

  property p_width;
    state_reg == ST_STROBE && tmr_reg >= width_reg && !ctrl_reg.handshake |=> !resultStrobe ##1 !resultStrobe;
  endproperty
  a_width: assert property (p_width) else $error("strobe not released after width");

  property p_noWait;
    !ctrl_reg.handshake && state_reg == ST_STROBE |=> state_reg != ST_WAIT;
  endproperty
  a_noWait: assert property (p_noWait) else $error("waited without handshake");

  property p_hold;
    state_reg == ST_WAIT && !ackIn && !toHit |=> resultStrobe && $stable(result_data_lines);
  endproperty
  a_hold: assert property (p_hold) else $error("result not held in handshake");

  property p_timeout;
    toHit |=> status_reg[par_out_pkg::ST_TIMEOUT] && state_reg == ST_IDLE && !resultStrobe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");

  property p_oneShotEnd;
    ctrl_reg.oneShot && !loadEvt && tick && pulseCnt_reg == 20'h00001 |=> !judgeOut;
  endproperty
  a_oneShotEnd: assert property (p_oneShotEnd) else $error("one-shot not released");

  property p_level;
    !ctrl_reg.oneShot && !loadEvt |=> $stable(judgeOut);
  endproperty
  a_level: assert property (p_level) else $error("level judgment changed");

  property p_ready;
    ctrl_reg.readySel && captureDone |=> readyOut;
  endproperty
  a_ready: assert property (p_ready) else $error("ready missing after capture");

  c_free: cover property (!ctrl_reg.handshake && sentEvt);
  c_ack: cover property (state_reg == ST_WAIT && ackIn);
  c_timeout: cover property (toHit);
  c_pulse: cover property (ctrl_reg.oneShot && $fell(judgeOut));
endmodule

// ==== testbench/parallel_result_output_port_bench.sv ====
// self-checking bench of the parallel result output port
`timescale 1ns/1ps
module parallel_result_output_port_bench;
  localparam int T = 2; // cycles per 0.1 ms tick, keeps the long timeout affordable
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic resultValid = 1'b0, trigIn = 1'b0, captureDone = 1'b0, measDone = 1'b0, er;
  par_out_pkg::result_t resultIn = 17'h00000;
  logic ackIn, resultStrobe, judgeOut, readyOut, irq, ackEnable = 1'b0;
  logic [7:0] ackDelay = 8'h3c;
  logic [15:0] result_data_lines, capturedData;
  int n_mismatch = 0, cmp_count = 0, n, m;
  // ------------------------------------------------------------
  // clock, design and partner
  // ------------------------------------------------------------
  // free-running 250 MHz clock
  always #2 clk_sys = ~clk_sys;
  par_result_out #(.TickCycles(T)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .resultValid(resultValid), .resultIn(resultIn), .trigIn(trigIn), .captureDone(captureDone),
    .measDone(measDone), .ackIn(ackIn), .result_data_lines(result_data_lines), .resultStrobe(resultStrobe),
    .judgeOut(judgeOut), .readyOut(readyOut), .irq(irq));
  result_receiver partner (.clk_sys(clk_sys), .rst_b(rst_b), .resultStrobe(resultStrobe),
    .result_data_lines(result_data_lines), .ackEnable(ackEnable), .ackDelay(ackDelay), .ackIn(ackIn),
    .capturedData(capturedData));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // apb master: a spare edge first so psel is never driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // wait states are allowed; only the watchdog ends a stuck transfer
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic send(input logic [15:0] d, input logic ng);
    @(posedge clk_sys);
    resultValid <= 1'b1;
    resultIn <= '{data: d, ng: ng};
    @(posedge clk_sys);
    resultValid <= 1'b0;
  endtask
  // which: 0 trigger, 1 capture done, 2 measurement done
  task automatic pulse(input int which);
    @(posedge clk_sys);
    {trigIn, captureDone, measDone} <= 3'h4 >> which;
    @(posedge clk_sys);
    {trigIn, captureDone, measDone} <= 3'h0;
    @(negedge clk_sys);
  endtask
  // counts negedges until the strobe (sel 0) or judgment line (sel 1) shows lvl
  task automatic waitLvl(input logic sel, input logic lvl, output int cnt);
    cnt = 0;
    while ((sel ? judgeOut : resultStrobe) !== lvl && cnt < 30000)
    begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rdchk("ctrl", par_out_pkg::OFS_CTRL, 32'h0);
    rdchk("cycle", par_out_pkg::OFS_CYCLE, 32'h64);
    rdchk("delay", par_out_pkg::OFS_DELAY, 32'h0);
    rdchk("width", par_out_pkg::OFS_WIDTH, 32'h32);
    rdchk("timeout", par_out_pkg::OFS_TIMEOUT, 32'h64);
    rdchk("pulse", par_out_pkg::OFS_PULSE, 32'h0);
    rdchk("mask", par_out_pkg::OFS_MASK, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, par_out_pkg::OFS_CYCLE, 32'h0);
    rdchk("cycle floor", par_out_pkg::OFS_CYCLE, 32'h14);
    apb(1'b1, par_out_pkg::OFS_CYCLE, 32'h64);
  endtask
  task automatic t_free;
    apb(1'b1, par_out_pkg::OFS_DELAY, 32'ha); // 1.0 ms delay
    apb(1'b1, par_out_pkg::OFS_MASK, 32'h2);
    send(16'h1234, 1'b1);
    waitLvl(1'b0, 1'b1, n);
    chk("data lines", result_data_lines, 16'h1234);
    chk("strobe delay", n >= 18 && n <= 26, 1'b1);
    waitLvl(1'b0, 1'b0, n);
    chk("strobe width", n >= 96 && n <= 104, 1'b1);
    chk("captured", capturedData, 16'h1234);
    repeat (2) @(negedge clk_sys);
    chk("judge held", judgeOut, 1'b1);
    chk("irq sent", irq, 1'b1);
    apb(1'b1, par_out_pkg::OFS_STATUS, 32'h2);
    // the clear lands at the access edge, so look once it has settled
    @(negedge clk_sys);
    chk("irq cleared", irq, 1'b0);
  endtask
  task automatic t_cycle;
    apb(1'b1, par_out_pkg::OFS_DELAY, 32'h0);
    apb(1'b1, par_out_pkg::OFS_WIDTH, 32'ha);
    apb(1'b1, par_out_pkg::OFS_CYCLE, 32'h14); // 2.0 ms, covers delay plus width
    send(16'h0a0a, 1'b0);
    send(16'h0b0b, 1'b0);
    send(16'h0c0c, 1'b0);
    waitLvl(1'b0, 1'b1, n);
    waitLvl(1'b0, 1'b0, n);
    waitLvl(1'b0, 1'b1, m);
    chk("output cycle", n + m >= 38 && n + m <= 46, 1'b1);
    chk("newest result", result_data_lines, 16'h0c0c);
    apb(1'b0, par_out_pkg::OFS_STATUS, 32'h0);
    chk("overrun", rd[2], 1'b1);
    apb(1'b1, par_out_pkg::OFS_STATUS, 32'h7);
    // let the last strobe finish so the next scenario starts from an idle port
    waitLvl(1'b0, 1'b0, n);
  endtask
  task automatic t_pol;
    apb(1'b1, par_out_pkg::OFS_CTRL, 32'h1);
    send(16'h00a5, 1'b0);
    waitLvl(1'b0, 1'b1, n);
    chk("ok data", result_data_lines, 16'hff5a);
    chk("ok judge", judgeOut, 1'b1);
    send(16'h0000, 1'b1);
    waitLvl(1'b0, 1'b0, n);
    waitLvl(1'b0, 1'b1, n);
    chk("judge changed", judgeOut, 1'b0);
    waitLvl(1'b0, 1'b0, n);
  endtask
  task automatic t_oneshot;
    apb(1'b1, par_out_pkg::OFS_CTRL, 32'h4);
    apb(1'b1, par_out_pkg::OFS_PULSE, 32'h1);
    send(16'h0001, 1'b1);
    waitLvl(1'b1, 1'b1, n);
    waitLvl(1'b1, 1'b0, n);
    chk("pulse time", n >= 18 && n <= 24, 1'b1);
    send(16'h0000, 1'b0);
    m = 0;
    // an unknown level counts as a pulse too
    repeat (80)
    begin
      @(negedge clk_sys);
      m += (judgeOut !== 1'b0);
    end
    chk("no pulse when passing", m, 0);
  endtask
  task automatic t_hand;
    apb(1'b1, par_out_pkg::OFS_CTRL, 32'h2);
    @(posedge clk_sys);
    ackEnable <= 1'b1;
    send(16'h00f0, 1'b0);
    waitLvl(1'b0, 1'b1, n);
    waitLvl(1'b0, 1'b0, n);
    chk("held to ack", n >= 59 && n <= 66, 1'b1);
    @(posedge clk_sys);
    ackEnable <= 1'b0;
    apb(1'b1, par_out_pkg::OFS_TIMEOUT, 32'ha);
    apb(1'b1, par_out_pkg::OFS_MASK, 32'h1);
    send(16'h000f, 1'b0);
    waitLvl(1'b0, 1'b1, n);
    waitLvl(1'b0, 1'b0, n);
    chk("timeout span", n >= 19996 && n <= 20006, 1'b1);
    repeat (2) @(negedge clk_sys);
    chk("irq timeout", irq, 1'b1);
    apb(1'b1, par_out_pkg::OFS_STATUS, 32'h1);
    @(negedge clk_sys);
    chk("irq timeout cleared", irq, 1'b0);
  endtask
  task automatic t_ready;
    apb(1'b1, par_out_pkg::OFS_CTRL, 32'h0);
    pulse(0);
    pulse(1);
    chk("ready on capture", readyOut, 1'b0);
    pulse(2);
    chk("ready on meas", readyOut, 1'b1);
    pulse(0);
    chk("ready cleared", readyOut, 1'b0);
    apb(1'b1, par_out_pkg::OFS_CTRL, 32'h8);
    pulse(1);
    chk("ready at capture", readyOut, 1'b1);
    // idle port, ready high, level judgment low, nothing pending
    rdchk("state", par_out_pkg::OFS_STATE, 32'h10);
  endtask
  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  // reset for three edges, then every scenario in turn
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_free();
    t_cycle();
    t_pol();
    t_oneshot();
    t_hand();
    t_ready();
    report_and_stop();
  end
  // the run needs about 21000 cycles; a hang is cut off well beyond that
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop();
  end
endmodule

// ==== testbench/result_receiver.sv ====
// behavioural receiving controller: samples the data lines under the strobe and acknowledges
`timescale 1ns/1ps
module result_receiver (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic resultStrobe,
  input wire logic [15:0] result_data_lines,
  input wire logic ackEnable,
  input wire logic [7:0] ackDelay,
  output logic ackIn,
  output logic [15:0] capturedData
);
  logic [7:0] waitCnt;
  // ------------------------------------------------------------
  // capture and acknowledge
  // ------------------------------------------------------------
  // ack waits ackDelay cycles so a slow partner can be shown; it is held until the strobe drops
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ackIn <= 1'b0;
      waitCnt <= 8'h00;
      capturedData <= 16'h0000;
    end
    else if (resultStrobe)
    begin
      capturedData <= result_data_lines;
      if (waitCnt != ackDelay)
        waitCnt <= waitCnt + 8'h01;
      ackIn <= ackIn || (ackEnable && waitCnt == ackDelay);
    end
    else
    begin
      ackIn <= 1'b0;
      waitCnt <= 8'h00;
    end
  end
endmodule
